// ### inc/amwp_pkg.sv
// constants for the host-side controller of a byte-wide async memory port
// assumes core_clk at 125 MHz (8 ns period)
package amwp_pkg;

   // ------------------------------------------------------------
   // bus widths
   // ------------------------------------------------------------
   localparam int ADDR_W = 17;
   localparam int DATA_W = 8;

   // ------------------------------------------------------------
   // timing in ns and derived cycle counts
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 8;
   localparam int T_CYCLE_NS     = 45;
   localparam int T_PULSE_NS     = 20;
   localparam int T_ADDR_END_NS  = 25;
   localparam int T_DATA_SU_NS   = 15;
   localparam int T_HIGH_NS      = 2;
   localparam int T_WH_EL_NS     = 12;
   localparam int T_READ_NS      = 45;

   // least times round up
   localparam int PULSE_CYC    =
      (T_ADDR_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYCLE_CYC    =
      (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HIGH_CYC_RAW =
      (T_WH_EL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HIGH_CYC     = (HIGH_CYC_RAW < 1) ? 1 : HIGH_CYC_RAW;
   // a read samples once the access time has passed and the data has
   // crossed both synchroniser flops
   localparam int READ_CYC     =
      (T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 2;

   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

   // ------------------------------------------------------------
   // controller states
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      AMWP_IDLE  = 4'b0001,
      AMWP_WRITE = 4'b0010,
      AMWP_READ  = 4'b0100,
      AMWP_RECOV = 4'b1000
   } amwp_state_t;

endpackage

// ### rtl/amwp_sync.sv
// two-flop synchroniser for the data pins read back from the memory
// assumes one clock; clear is the asynchronous reset
module amwp_sync
   import amwp_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              rst,
   input  wire logic              ce,
   input  wire logic [DATA_W-1:0] async_in,
   output logic      [DATA_W-1:0] sync_out
);

   logic [DATA_W-1:0] stage1;
   logic [DATA_W-1:0] next_stage1;
   logic [DATA_W-1:0] next_sync_out;

   always_comb
   begin
      next_stage1   = ce ? async_in : stage1;
      next_sync_out = ce ? stage1 : sync_out;
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         stage1   <= '0;
         sync_out <= '0;
      end
      else
      begin
         stage1   <= next_stage1;
         sync_out <= next_sync_out;
      end
   end

endmodule // amwp_sync

// ### rtl/amwp_host.sv
// host controller driving a byte-wide asynchronous memory over its pins
// assumes core_clk 125 MHz, rst async active high, ce freezes all state
//
// Contract
// - after strobe or select rises, hold it high at least 2 ns.
// - successive select falling edges at least 45 ns apart.
// - every write cycle lasts at least 45 ns address to address.
// - address stable at strobe fall, valid 25 ns before write end.
// - strobe-controlled write keeps strobe low at least 20 ns.
// - select-controlled write keeps select low at least 20 ns.
// - write data valid 15 ns before write end, held after.
// - shortened recovery: reassert select no sooner than 12 ns after strobe.
// - strobe held high throughout every read cycle.
// - address valid before or with select falling for reads.
// - continuous-select read: outputs follow each address change.
module amwp_host
   import amwp_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              rst,
   input  wire logic              ce,
   input  wire logic              req_valid,
   input  wire logic              req_write,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic [DATA_W-1:0] req_wdata,
   output logic                   req_ready,
   output logic                   rsp_valid,
   output logic      [DATA_W-1:0] rsp_rdata,
   output logic      [ADDR_W-1:0] mem_addr,
   output logic                   mem_sel_n,
   output logic                   mem_wr_n,
   output logic                   mem_oe_n,
   output logic      [DATA_W-1:0] mem_dq_out,
   output logic                   mem_dq_oe,
   input  wire logic [DATA_W-1:0] mem_dq_in
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   amwp_state_t       state;
   amwp_state_t       next_state;
   logic [CNT_W-1:0]  cnt;
   logic [CNT_W-1:0]  next_cnt;
   logic [CNT_W-1:0]  gap;
   logic [CNT_W-1:0]  next_gap;
   logic [ADDR_W-1:0] next_mem_addr;
   logic              next_mem_sel_n;
   logic              next_mem_wr_n;
   logic              next_mem_oe_n;
   logic [DATA_W-1:0] next_mem_dq_out;
   logic              next_mem_dq_oe;
   logic              next_rsp_valid;
   logic [DATA_W-1:0] next_rsp_rdata;
   logic [DATA_W-1:0] dq_sync;

   // ------------------------------------------------------------
   // read data synchroniser
   // ------------------------------------------------------------
   amwp_sync u_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .ce       (ce),
      .async_in (mem_dq_in),
      .sync_out (dq_sync)
   );

   // new access only when idle and the select-to-select gap has run out
   assign req_ready = ce && (state == AMWP_IDLE) && (gap == CNT_ZERO);

   // ------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------
   always_comb
   begin
      next_state      = state;
      next_cnt        = cnt;
      next_gap        = (gap != CNT_ZERO) ? gap - CNT_ONE : gap;
      next_mem_addr   = mem_addr;
      next_mem_sel_n  = mem_sel_n;
      next_mem_wr_n   = mem_wr_n;
      next_mem_oe_n   = mem_oe_n;
      next_mem_dq_out = mem_dq_out;
      next_mem_dq_oe  = mem_dq_oe;
      next_rsp_valid  = 1'b0;
      next_rsp_rdata  = rsp_rdata;
      unique case (state)
         AMWP_IDLE:
         begin
            if (req_valid && req_ready)
            begin
               // address, select and strobe (oe on a read) change together: 0 ns setup
               next_mem_addr  = req_addr;
               next_mem_sel_n = 1'b0;
               next_gap       = CNT_W'(CYCLE_CYC - 1);
               if (req_write)
               begin
                  // oe stays high: strobe-and-select write, outputs off
                  next_mem_wr_n   = 1'b0;
                  next_mem_oe_n   = 1'b1;
                  next_mem_dq_out = req_wdata;
                  next_mem_dq_oe  = 1'b1;
                  next_cnt        = CNT_W'(PULSE_CYC);
                  next_state      = AMWP_WRITE;
               end
               else
               begin
                  next_mem_wr_n  = 1'b1;
                  next_mem_oe_n  = 1'b0;
                  next_mem_dq_oe = 1'b0;
                  next_cnt       = CNT_W'(READ_CYC);
                  next_state     = AMWP_READ;
               end
            end
         end
         AMWP_WRITE:
         begin
            if (cnt > CNT_ONE)
               next_cnt = cnt - CNT_ONE;
            else
            begin
               // strobe and select rise together; data and address held
               next_mem_wr_n  = 1'b1;
               next_mem_sel_n = 1'b1;
               next_cnt       = CNT_W'(HIGH_CYC);
               next_state     = AMWP_RECOV;
            end
         end
         AMWP_READ:
         begin
            if (cnt > CNT_ONE)
               next_cnt = cnt - CNT_ONE;
            else
            begin
               next_rsp_rdata = dq_sync;
               next_rsp_valid = 1'b1;
               next_mem_sel_n = 1'b1;
               next_mem_oe_n  = 1'b1;
               next_cnt       = CNT_W'(HIGH_CYC);
               next_state     = AMWP_RECOV;
            end
         end
         AMWP_RECOV:
         begin
            // address and data held through recovery, then bus released
            if (cnt > CNT_ONE)
               next_cnt = cnt - CNT_ONE;
            else
            begin
               next_mem_dq_oe = 1'b0;
               next_cnt       = CNT_ZERO;
               next_state     = AMWP_IDLE;
            end
         end
         default:
         begin
            next_state     = AMWP_IDLE;
            next_mem_sel_n = 1'b1;
            next_mem_wr_n  = 1'b1;
            next_mem_oe_n  = 1'b1;
            next_mem_dq_oe = 1'b0;
         end
      endcase
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         state      <= AMWP_IDLE;
         cnt        <= CNT_ZERO;
         gap        <= CNT_ZERO;
         mem_addr   <= '0;
         mem_sel_n  <= 1'b1;
         mem_wr_n   <= 1'b1;
         mem_oe_n   <= 1'b1;
         mem_dq_out <= '0;
         mem_dq_oe  <= 1'b0;
         rsp_valid  <= 1'b0;
         rsp_rdata  <= '0;
      end
      else if (ce)
      begin
         state      <= next_state;
         cnt        <= next_cnt;
         gap        <= next_gap;
         mem_addr   <= next_mem_addr;
         mem_sel_n  <= next_mem_sel_n;
         mem_wr_n   <= next_mem_wr_n;
         mem_oe_n   <= next_mem_oe_n;
         mem_dq_out <= next_mem_dq_out;
         mem_dq_oe  <= next_mem_dq_oe;
         rsp_valid  <= next_rsp_valid;
         rsp_rdata  <= next_rsp_rdata;
      end
   end

endmodule // amwp_host

// ### tb/amwp_host_sva.sv
// pin timing checker for the async memory host controller
// assumes bind onto amwp_host, one clock, rst async active high
module amwp_host_chk
   import amwp_pkg::*;
(
   input wire logic              core_clk,
   input wire logic              rst,
   input wire logic              rsp_valid,
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic              mem_sel_n,
   input wire logic              mem_wr_n,
   input wire logic              mem_oe_n,
   input wire logic [DATA_W-1:0] mem_dq_out,
   input wire logic              mem_dq_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   property p_wlen; $fell(mem_wr_n) |-> !mem_wr_n[*4]; endproperty
   a_wlen: assert property (p_wlen) else $error("short strobe");
   property p_slen; $fell(mem_sel_n) |-> !mem_sel_n[*3]; endproperty
   a_slen: assert property (p_slen) else $error("short select");
   property p_gap; $fell(mem_sel_n) |=> !$fell(mem_sel_n)[*5]; endproperty
   a_gap: assert property (p_gap) else $error("select too soon");
   property p_rec; $rose(mem_wr_n) |-> mem_sel_n[*2]; endproperty
   a_rec: assert property (p_rec) else $error("short recovery");
   property p_hold;
      $rose(mem_wr_n) |=> $stable(mem_addr) && $stable(mem_dq_out);
   endproperty
   a_hold: assert property (p_hold) else $error("no hold");
   property p_stab;
      !mem_sel_n && !$past(mem_sel_n) |-> $stable(mem_addr);
   endproperty
   a_stab: assert property (p_stab) else $error("addr moved");
   property p_both;
      $fell(mem_wr_n) |-> $fell(mem_sel_n) ##4
         ($rose(mem_wr_n) && $rose(mem_sel_n));
   endproperty
   a_both: assert property (p_both) else $error("edges apart");
   property p_rd; !mem_oe_n |-> mem_wr_n && !mem_dq_oe; endproperty
   a_rd: assert property (p_rd) else $error("strobe in read");
   property p_dat; $fell(mem_wr_n) |-> mem_dq_oe[*6]; endproperty
   a_dat: assert property (p_dat) else $error("data off");
   property p_rsp; $fell(mem_oe_n) |-> ##8 rsp_valid; endproperty
   a_rsp: assert property (p_rsp) else $error("late answer");
   c_wr: cover property ($rose(mem_wr_n));
   c_rd: cover property (rsp_valid);
   c_b2b: cover property ($fell(mem_sel_n) ##7 $fell(mem_sel_n));
endmodule // amwp_host_chk

bind amwp_host amwp_host_chk amwp_host_chk_i (
   .core_clk(core_clk), .rst(rst), .rsp_valid(rsp_valid),
   .mem_addr(mem_addr), .mem_sel_n(mem_sel_n), .mem_wr_n(mem_wr_n),
   .mem_oe_n(mem_oe_n), .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe));

// ### tb/amwp_mem_model.sv
// behavioural byte-wide async memory on the host pins
// assumes no pulls on the data lines; contents survive host reset
module amwp_mem_model
   import amwp_pkg::*;
#(
   parameter int T_ACC = 45
)
(
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic              sel_n,
   input  wire logic              wr_n,
   input  wire logic              oe_n,
   input  wire logic [DATA_W-1:0] host_dq,
   input  wire logic              host_oe,
   output logic      [DATA_W-1:0] dq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [DATA_W-1:0] store [bit [ADDR_W-1:0]];
   logic [DATA_W-1:0] rd_q;
   logic [DATA_W-1:0] last_q = 8'h00;
   logic              drive;
   always @* if (!sel_n && !wr_n) store[addr] = host_dq;
   assign drive = !sel_n && !oe_n && wr_n;
   // read data follows every address change after the access time
   always @(addr, drive)
      rd_q <= #(T_ACC) store.exists(addr) ? store[addr] : ~addr[7:0];
   always @(rd_q, drive) if (drive) last_q = rd_q;
   // released lines show the inverse of the last driven value
   assign dq = host_oe ? host_dq : (drive ? rd_q : ~last_q);
endmodule // amwp_mem_model

// ### tb/tb.sv
// self-checking bench for the async memory host controller
// assumes the memory model on the pins and the checker bound in
module tb
   import amwp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic              core_clk = 0;
   logic              rst = 1;
   logic              req_valid = 0;
   logic              req_write = 0;
   logic [ADDR_W-1:0] req_addr = '0;
   logic [DATA_W-1:0] req_wdata = '0;
   logic              req_ready, rsp_valid, mem_sel_n, mem_wr_n, mem_oe_n;
   logic              mem_dq_oe;
   logic [DATA_W-1:0] rsp_rdata, mem_dq_out, mem_dq_in;
   logic [ADDR_W-1:0] mem_addr, a;
   logic [15:0]       lf = 16'h003f;
   logic [DATA_W-1:0] shadow [bit [ADDR_W-1:0]];
   int                n_mismatch = 0;
   int                comparisons = 0;
   int                cyc = 0;
   int                last = -100;
   always #4 core_clk = ~core_clk;
   always @(posedge core_clk) cyc <= cyc + 1;
   amwp_host amwp_host_i (.core_clk(core_clk), .rst(rst), .ce(1'b1),
      .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
      .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .mem_addr(mem_addr), .mem_sel_n(mem_sel_n),
      .mem_wr_n(mem_wr_n), .mem_oe_n(mem_oe_n), .mem_dq_out(mem_dq_out),
      .mem_dq_oe(mem_dq_oe), .mem_dq_in(mem_dq_in));
   amwp_mem_model amwp_mem_model_i (.addr(mem_addr), .sel_n(mem_sel_n),
      .wr_n(mem_wr_n), .oe_n(mem_oe_n), .host_dq(mem_dq_out),
      .host_oe(mem_dq_oe), .dq(mem_dq_in));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic summarize();
      if (n_mismatch == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task automatic access(input logic wr, input logic [ADDR_W-1:0] ad,
                         input logic [DATA_W-1:0] d);
      int i;
      @(negedge core_clk);
      req_valid = 1;
      req_write = wr;
      req_addr = ad;
      req_wdata = d;
      for (i = 0; i < 40 && req_ready !== 1'b1; i++) @(negedge core_clk);
      if (i == 40) n_mismatch++;
      if (i == 40) summarize();
      check(cyc - last >= CYCLE_CYC, 1);
      last = cyc;
      @(negedge core_clk);
      req_valid = 0;
      check(req_ready, 1'b0);
      if (wr) shadow[ad] = d;
      else
      begin
         for (i = 1; i < 20 && rsp_valid !== 1'b1; i++) @(negedge core_clk);
         check(i, READ_CYC + 1);
         check(rsp_rdata, shadow[ad]);
      end
   endtask
   initial
   begin
      repeat (16) @(posedge core_clk);
      @(negedge core_clk) rst = 0;
      access(1, 17'h1ffff, 8'hff);
      access(1, 17'h00000, 8'h00);
      access(0, 17'h1ffff, 8'h00);
      access(0, 17'h00000, 8'h00);
      for (int k = 0; k < 40; k++)
      begin
         lf = lfsr(lf);
         a = {lf[3], lf};
         lf = lfsr(lf);
         access(1, a, lf[7:0]);
         access(0, a, 8'h00);
      end
      @(negedge core_clk) rst = 1;
      repeat (2) @(negedge core_clk);
      rst = 0;
      access(0, 17'h1ffff, 8'h00);
      summarize();
   end
   initial
   begin
      repeat (100000) @(posedge core_clk);
      n_mismatch++;
      summarize();
   end
endmodule // tb
